// file: rfsdc_pkg.sv
// Constants, register map and types for the synthesizer divider control block.
// How it works
// - Main divider is a 5-bit swallow, 9-bit program counter and prescaler.
// - Prescaler divides VCO edges by 33 or 32, chosen by swallow count.
// - Divide by 33 until swallow ends, by 32 until program ends, reload.
// - Total main ratio equals swallow plus 32 times program.
// - Reference divider divides crystal edges by code plus one, 1..256.
// - Channel step equals reference rate; output is ratio times reference.
// - Phase detector reacts to both phase and frequency error.
// - Detector drives separate pump-up and pump-down outputs.
// - Peak pump current is 250, 500 or 1000 microamperes.
// - Amplifier has full, 10 dB, 20 dB and off states.
// - In receive the amplifier is off while the VCO keeps running.
// - In on-off keying the amplifier follows the transmit bit.
// - In FSK the extra crystal load follows the transmit bit.
// - A trim field switches capacitors across the crystal.
// - Slicer has a learn state and a hold state.
// - Pump current code sits in bits 3:2 of preset zero.
// - Each preset holds its own attenuation field in bits 7:6.
// - Bit 4 of preset one selects FSK or on-off keying.
// - A select pin swaps between the two presets at once.
package rfsdc_pkg;
    localparam logic [7:0]  ADDR_PRESET0 = 8'h00;
    localparam logic [7:0]  ADDR_PRESET1 = 8'h04;
    localparam logic [7:0]  ADDR_REFDIV  = 8'h08;
    localparam logic [7:0]  ADDR_TRIM    = 8'h0C;
    localparam logic [7:0]  ADDR_SLICE   = 8'h10;
    localparam logic [7:0]  ADDR_STATUS  = 8'h14;
    localparam int          SWAL_LSB     = 17;
    localparam int          SWAL_W       = 5;
    localparam int          PROG_LSB     = 8;
    localparam int          PROG_W       = 9;
    localparam int          ATTEN_LSB    = 6;
    localparam int          TXRX_BIT     = 5;
    localparam int          FSK_BIT      = 4;
    localparam int          CP_LSB       = 2;
    localparam int          REF_W        = 8;
    localparam int          TRIM_W       = 3;
    localparam logic [31:0] PRESET_MASK  = 32'h003F_FFFD;
    localparam logic [31:0] PRESET_RST   = 32'h0000_1F00;
    localparam logic [7:0]  REFDIV_RST   = 8'h00;
    localparam logic [2:0]  TRIM_RST     = 3'h0;
    localparam logic [5:0]  PRESC_END33  = 6'h20;
    localparam logic [5:0]  PRESC_END32  = 6'h1F;
    localparam logic [1:0]  CP_250UA     = 2'h0;
    localparam logic [1:0]  CP_500UA     = 2'h1;
    localparam logic [1:0]  CP_1000UA    = 2'h2;
    localparam logic [1:0]  CP_SPARE     = 2'h3;
    typedef enum logic [1:0] {AMP_FULL, AMP_ATT10, AMP_ATT20, AMP_OFF} rfsdc_amp_e;
endpackage : rfsdc_pkg

// file: rfsdc_div_if.sv
// Interface between the control top and the dual-modulus main divider.
`timescale 1ns/1ns
interface rfsdc_div_if;
    logic       vco_edge;
    logic [4:0] swallow;
    logic [8:0] prog_val;
    logic       div_pulse;
    logic       mod33;
    modport div (input vco_edge, swallow, prog_val, output div_pulse, mod33);
    modport ctl (output vco_edge, swallow, prog_val, input div_pulse, mod33);
endinterface : rfsdc_div_if

// file: rfsdc_main_div.sv
// Dual-modulus main divider: prescaler with swallow and program counters.
`timescale 1ns/1ns
module rfsdc_main_div
    import rfsdc_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    rfsdc_div_if.div  dv
);
    logic [5:0]  pre_q;
    logic [4:0]  swal_q;
    logic [8:0]  prog_q;
    logic        pulse_q;
    logic        presc_end;
    logic        reload;

    // Prescaler modulus is 33 while swallow counts remain, else 32.
    assign presc_end = dv.vco_edge && (pre_q == ((swal_q != 5'h00) ? PRESC_END33 : PRESC_END32));
    assign reload    = presc_end && (prog_q <= 9'h001);

    // Prescaler edge counter.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || presc_end) begin
            pre_q <= 6'h00;
        end else if (dv.vco_edge) begin
            pre_q <= pre_q + 6'h01;
        end
    end

    // Swallow and program counters; both reload at the end of a cycle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            swal_q <= 5'h00;
            prog_q <= 9'h000;
        end else if (reload) begin
            swal_q <= dv.swallow;
            prog_q <= dv.prog_val;
        end else if (presc_end) begin
            swal_q <= swal_q - {4'h0, swal_q != 5'h00};
            prog_q <= prog_q - 9'h001;
        end
    end

    // One output pulse per completed cycle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= reload;
        end
    end

    assign dv.div_pulse = pulse_q;
    assign dv.mod33     = (swal_q != 5'h00);

    // Helper logic counting VCO edges per cycle for the ratio check.
    logic [15:0] ecnt_q;
    logic [13:0] lat_n_q;
    logic        ok_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ecnt_q  <= 16'h0000;
            lat_n_q <= 14'h0000;
            ok_q    <= 1'b0;
        end else if (reload) begin
            ecnt_q  <= 16'h0000;
            lat_n_q <= {dv.prog_val, 5'h00} + {9'h000, dv.swallow};
            ok_q    <= 1'b1;
        end else if (dv.vco_edge) begin
            ecnt_q  <= ecnt_q + 16'h0001;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    AST_RATIO: assert property (reload && ok_q && dv.prog_val >= 9'h01F
        && lat_n_q >= 14'h3E0 |-> ecnt_q + 16'h0001 == {2'b00, lat_n_q})
        else $error("Main divider ratio differs from swallow plus 32 times program.");
    AST_PULSE: assert property (reload |=> dv.div_pulse ##1 !dv.div_pulse)
        else $error("Divider pulse missing or longer than one cycle.");
endmodule : rfsdc_main_div

// file: rfsdc_top.sv
// Synthesizer divider control top: APB registers, dividers, detector, keying.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
module rfsdc_top
    import rfsdc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        vco_in,
    input  wire logic        xtal_in,
    input  wire logic        preset_sel,
    input  wire logic        tx_bit,
    output logic             pump_up,
    output logic             pump_dn,
    output logic      [1:0]  cp_current,
    output logic             power_amp_stage_on,
    output logic      [1:0]  power_amp_stage_atten,
    output logic             vco_run,
    output logic             fsk_load,
    output logic      [2:0]  xtal_trim,
    output logic             slicer_hold
);
    logic [31:0] preset_zero_q;
    logic [31:0] preset_one_q;
    logic [7:0]  refdiv_q;
    logic [2:0]  trim_q;
    logic        hold_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        vco_d_q;
    logic        xtal_d_q;
    logic        vco_edge;
    logic        xtal_edge;
    logic [7:0]  ref_cnt_q;
    logic        ref_pulse_q;
    logic        up_q;
    logic        dn_q;
    logic [1:0]  cp_q;
    logic        amp_on_q;
    logic [1:0]  amp_att_q;
    logic        vco_run_q;
    logic        fsk_load_q;
    logic [2:0]  xtal_trim_q;
    logic        slicer_hold_q;
    logic [31:0] active;
    logic        tx_mode;
    logic        fsk_mode;
    logic        wr_en;
    logic        setup;
    logic        mapped;
    rfsdc_amp_e  amp_state;

    rfsdc_div_if dif ();

    // APB phase decode; writes land at the completing access edge.
    assign setup  = psel && !penable;
    assign wr_en  = psel && penable && pready_q && pwrite && !pslverr_q;
    assign mapped = (paddr == ADDR_PRESET0) || (paddr == ADDR_PRESET1) ||
                    (paddr == ADDR_REFDIV) || (paddr == ADDR_TRIM) ||
                    (paddr == ADDR_SLICE) || (paddr == ADDR_STATUS);

    // The select pin picks a preset word combinationally, so swaps are instant.
    assign active   = preset_sel ? preset_one_q : preset_zero_q;
    assign tx_mode  = active[TXRX_BIT];
    assign fsk_mode = preset_one_q[FSK_BIT];

    // Amplifier state as seen by software.
    always_comb begin
        if (!tx_mode) begin
            amp_state = AMP_OFF;
        end else begin
            unique case (active[ATTEN_LSB +: 2])
                2'h0:    amp_state = AMP_FULL;
                2'h1:    amp_state = AMP_ATT10;
                default: amp_state = AMP_ATT20;
            endcase
        end
    end

    // Ready is raised in the cycle after setup so every access takes one wait-free beat.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !mapped;
        end
    end

    // Read data is captured in the setup cycle and held through the access.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            unique case (paddr)
                ADDR_PRESET0: prdata_q <= preset_zero_q;
                ADDR_PRESET1: prdata_q <= preset_one_q;
                ADDR_REFDIV:  prdata_q <= {24'h00_0000, refdiv_q};
                ADDR_TRIM:    prdata_q <= {29'h0000_0000, trim_q};
                ADDR_SLICE:   prdata_q <= {31'h0000_0000, hold_q};
                ADDR_STATUS:  prdata_q <= {25'h000_0000, amp_state, dif.mod33,
                                           up_q, dn_q, preset_sel, 1'b0};
                default:      prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Two preset configuration words.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            preset_zero_q <= PRESET_RST;
            preset_one_q  <= PRESET_RST;
        end else if (wr_en && paddr == ADDR_PRESET0) begin
            preset_zero_q <= pwdata & PRESET_MASK;
        end else if (wr_en && paddr == ADDR_PRESET1) begin
            preset_one_q  <= pwdata & PRESET_MASK;
        end
    end

    // Reference divisor, crystal trim and slicer control.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            refdiv_q <= REFDIV_RST;
            trim_q   <= TRIM_RST;
            hold_q   <= 1'b0;
        end else if (wr_en) begin
            if (paddr == ADDR_REFDIV) begin
                refdiv_q <= pwdata[REF_W-1:0];
            end
            if (paddr == ADDR_TRIM) begin
                trim_q <= pwdata[TRIM_W-1:0];
            end
            if (paddr == ADDR_SLICE) begin
                hold_q <= pwdata[0];
            end
        end
    end

    // Rising edges of the VCO and crystal signals.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vco_d_q  <= 1'b0;
            xtal_d_q <= 1'b0;
        end else begin
            vco_d_q  <= vco_in;
            xtal_d_q <= xtal_in;
        end
    end
    assign vco_edge  = vco_in && !vco_d_q;
    assign xtal_edge = xtal_in && !xtal_d_q;

    // Main divider fed from the active preset.
    assign dif.vco_edge = vco_edge;
    assign dif.swallow  = active[SWAL_LSB +: SWAL_W];
    assign dif.prog_val = active[PROG_LSB +: PROG_W];

    rfsdc_main_div u_div (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .dv      (dif.div)
    );

    // Reference divider: code n divides by n plus one, so 1..256.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ref_cnt_q   <= 8'h00;
            ref_pulse_q <= 1'b0;
        end else begin
            ref_pulse_q <= xtal_edge && (ref_cnt_q >= refdiv_q);
            if (xtal_edge) begin
                ref_cnt_q <= (ref_cnt_q >= refdiv_q) ? 8'h00 : ref_cnt_q + 8'h01;
            end
        end
    end

    // Phase-frequency detector: reference leads set up, divider leads set down.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else if ((up_q || ref_pulse_q) && (dn_q || dif.div_pulse)) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else begin
            up_q <= up_q || ref_pulse_q;
            dn_q <= dn_q || dif.div_pulse;
        end
    end

    // Pump current code from preset zero; the spare code acts as the top step.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cp_q <= CP_250UA;
        end else if (preset_zero_q[CP_LSB +: 2] == CP_SPARE) begin
            cp_q <= CP_1000UA;
        end else begin
            cp_q <= preset_zero_q[CP_LSB +: 2];
        end
    end

    // Amplifier gating: off in receive, keyed by the transmit bit in OOK.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            amp_on_q  <= 1'b0;
            amp_att_q <= 2'h0;
        end else begin
            amp_on_q  <= tx_mode && (fsk_mode || tx_bit);
            amp_att_q <= active[ATTEN_LSB +: 2];
        end
    end

    // FSK load switch, trim and slicer outputs; the VCO always runs.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fsk_load_q    <= 1'b0;
            xtal_trim_q   <= TRIM_RST;
            slicer_hold_q <= 1'b0;
            vco_run_q     <= 1'b1;
        end else begin
            fsk_load_q    <= tx_mode && fsk_mode && tx_bit;
            xtal_trim_q   <= trim_q;
            slicer_hold_q <= hold_q;
            vco_run_q     <= 1'b1;
        end
    end

    assign prdata                = prdata_q;
    assign pready                = pready_q;
    assign pslverr               = pslverr_q;
    assign pump_up               = up_q;
    assign pump_dn               = dn_q;
    assign cp_current            = cp_q;
    assign power_amp_stage_on    = amp_on_q;
    assign power_amp_stage_atten = amp_att_q;
    assign vco_run               = vco_run_q;
    assign fsk_load              = fsk_load_q;
    assign xtal_trim             = xtal_trim_q;
    assign slicer_hold           = slicer_hold_q;

    // Helper logic counting crystal edges between reference pulses.
    logic [8:0] xcnt_q;
    logic       ref_ok_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            xcnt_q   <= 9'h000;
            ref_ok_q <= 1'b0;
        end else begin
            if (ref_pulse_q) begin
                xcnt_q <= {8'h00, xtal_edge};
            end else if (xtal_edge) begin
                xcnt_q <= xcnt_q + 9'h001;
            end
            if (ref_pulse_q) begin
                ref_ok_q <= 1'b1;
            end else if (wr_en && paddr == ADDR_REFDIV) begin
                ref_ok_q <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_apb_setup;
        psel && !penable;
    endsequence
    sequence s_apb_access;
        psel && penable && pready;
    endsequence

    AST_APB_READY: assert property (s_apb_setup |=> pready ##1 !pready)
        else $error("APB ready not given one cycle after setup.");
    AST_REF_PERIOD: assert property (ref_pulse_q && ref_ok_q && $stable(refdiv_q)
        |-> xcnt_q == {1'b0, refdiv_q} + 9'h001)
        else $error("Reference period differs from divisor plus one.");
    AST_PFD_EXCL: assert property (!(pump_up && pump_dn))
        else $error("Both pump outputs asserted together.");
    AST_PFD_UP: assert property (ref_pulse_q && !dn_q && !dif.div_pulse |=> pump_up)
        else $error("Reference pulse failed to raise pump-up.");
    AST_PFD_DN: assert property (dif.div_pulse && !up_q && !ref_pulse_q |=> pump_dn)
        else $error("Divider pulse failed to raise pump-down.");
    AST_CP_MAP: assert property (##1 cp_current ==
        (((($past(preset_zero_q) >> CP_LSB) & 32'h3) == 32'h3)
        ? CP_1000UA : $past(preset_zero_q[CP_LSB +: 2])))
        else $error("Pump current code mapped wrongly.");
    AST_RX_OFF: assert property (!tx_mode |=> !power_amp_stage_on && vco_run)
        else $error("Amplifier on or VCO stopped in receive.");
    AST_OOK_KEY: assert property (tx_mode && !fsk_mode |=> power_amp_stage_on == $past(tx_bit))
        else $error("Amplifier does not follow transmit bit in on-off keying.");
    AST_FSK_LOAD: assert property (tx_mode && fsk_mode |=> fsk_load == $past(tx_bit)
        && power_amp_stage_on)
        else $error("Crystal load does not follow transmit bit in FSK.");
    AST_PRESET_SWAP: assert property ($changed(preset_sel) && $stable(preset_zero_q)
        && $stable(preset_one_q) |=> power_amp_stage_atten == $past(active[ATTEN_LSB +: 2]))
        else $error("Preset select did not swap attenuation at once.");
    AST_SLICER: assert property (s_apb_access ##0 pwrite && paddr == ADDR_SLICE
        |=> ##1 slicer_hold == $past(pwdata[0], 2))
        else $error("Slicer hold does not follow its control bit.");
endmodule : rfsdc_top

// file: rfsdc_osc_model.sv
// Behavioural VCO and crystal sources that count the rising edges they emit.
`timescale 1ns/1ns
module rfsdc_osc_model #(
    parameter int HALF = 6
) (
    input  wire logic sys_clk,
    input  wire logic vco_en,
    input  wire logic xtal_en,
    input  wire logic clr,
    output logic      vco_in,
    output logic      xtal_in,
    output int        vco_cnt,
    output int        xtal_cnt
);
    int ph;
    // Both sources start low with cleared counters.
    initial begin
        ph = 0;
        vco_in = 1'b0;
        xtal_in = 1'b0;
        vco_cnt = 0;
        xtal_cnt = 0;
    end
    // A stopped source rests low, so no edge appears outside a measurement.
    always @(posedge sys_clk) begin
        ph <= (ph == HALF - 1) ? 0 : ph + 1;
        if (clr) begin
            vco_cnt <= 0;
            xtal_cnt <= 0;
        end else if (ph == HALF - 1) begin
            vco_cnt <= vco_cnt + int'(vco_en & ~vco_in);
            xtal_cnt <= xtal_cnt + int'(xtal_en & ~xtal_in);
        end
        if (ph == HALF - 1) begin
            vco_in <= vco_en & ~vco_in;
            xtal_in <= xtal_en & ~xtal_in;
        end
    end
endmodule : rfsdc_osc_model

// file: tb_top.sv
// Self-checking bench for the synthesizer divider control top.
`timescale 1ns/1ns
module tb_top;
    import rfsdc_pkg::*;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, w0, w1;
    logic        pready, pslverr, err, vco_in, xtal_in, pump_up, pump_dn, vco_run;
    logic        preset_sel = 1'b0, tx_bit = 1'b0, vco_en = 1'b0, xtal_en = 1'b0, clr = 1'b0;
    logic        amp_on, fsk_load, slicer_hold;
    logic [1:0]  cp_current, amp_att;
    logic [2:0]  xtal_trim;
    int          mismatches = 0, n_checks = 0, seed = 43, vco_cnt, xtal_cnt;

    // Free-running 20 MHz clock.
    always #25 sys_clk = ~sys_clk;

    rfsdc_top rfsdc_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vco_in(vco_in), .xtal_in(xtal_in),
        .preset_sel(preset_sel), .tx_bit(tx_bit), .pump_up(pump_up), .pump_dn(pump_dn),
        .cp_current(cp_current), .power_amp_stage_on(amp_on), .power_amp_stage_atten(amp_att),
        .vco_run(vco_run), .fsk_load(fsk_load), .xtal_trim(xtal_trim),
        .slicer_hold(slicer_hold));
    rfsdc_osc_model rfsdc_osc_model_i (.sys_clk(sys_clk), .vco_en(vco_en), .xtal_en(xtal_en),
        .clr(clr), .vco_in(vco_in), .xtal_in(xtal_in), .vco_cnt(vco_cnt), .xtal_cnt(xtal_cnt));

    // Builds a preset word from its fields.
    function automatic logic [31:0] pw(input logic [4:0] sw, input logic [8:0] pg,
        input logic [1:0] at, input logic tx, input logic fk, input logic [1:0] cp);
        return {10'h000, sw, pg, at, tx, fk, cp, 2'h0};
    endfunction : pw
    // Expected main division ratio.
    function automatic logic [31:0] ratio(input logic [4:0] sw, input logic [8:0] pg);
        return 32'(sw) + 32'h20 * 32'(pg);
    endfunction : ratio

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc
    // One APB transfer; read data and error are taken at the pready edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rchk
    // Runs one source until a pump output reaches a level, returning the edges sent.
    task automatic run_src(input logic v, input logic up, input logic lvl, output int n);
        int k;
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        vco_en <= v;
        xtal_en <= ~v;
        k = 0;
        while ((up ? pump_up : pump_dn) !== lvl && k < 20000) begin
            @(posedge sys_clk);
            k++;
        end
        if (k == 20000) mismatches++;
        vco_en <= 1'b0;
        xtal_en <= 1'b0;
        n = v ? vco_cnt : xtal_cnt;
        cyc(12);
    endtask : run_src
    // Aligns both dividers, then measures reference and main periods through the pumps.
    task automatic div_round(input logic [4:0] sw, input logic [8:0] pg, input logic [7:0] r);
        int n;
        apb(1'b1, ADDR_PRESET0, pw(sw, pg, 2'h0, 1'b0, 1'b0, 2'h0));
        apb(1'b1, ADDR_REFDIV, {24'h0, r});
        run_src(1'b1, 1'b0, 1'b1, n);
        run_src(1'b0, 1'b0, 1'b0, n);
        run_src(1'b0, 1'b1, 1'b1, n);
        check(n, 32'(r) + 32'h1);
        run_src(1'b1, 1'b1, 1'b0, n);
        check(n, ratio(sw, pg));
        run_src(1'b1, 1'b0, 1'b1, n);
        check(n, ratio(sw, pg));
        run_src(1'b0, 1'b0, 1'b0, n);
        check(n, 32'(r) + 32'h1);
    endtask : div_round
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // Cuts a hung run short.
    initial begin
        #(50 * 100000);
        mismatches++;
        tally_and_finish();
    end

    // Main test sequence.
    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rchk(ADDR_PRESET0, PRESET_RST);
        rchk(ADDR_PRESET1, PRESET_RST);
        rchk(ADDR_REFDIV, 32'h0);
        rchk(ADDR_TRIM, 32'h0);
        check(vco_run, 1'b1);
        apb(1'b1, 8'h18, 32'hFFFF_FFFF);
        check(err, 1'b1);
        rchk(8'h18, 32'h0);
        check(err, 1'b1);
        $display("reset and map test done");
        for (int i = 0; i < 6; i++) begin
            w0 = $random(seed);
            apb(1'b1, ADDR_PRESET0, w0);
            apb(1'b1, ADDR_PRESET1, ~w0);
            apb(1'b1, ADDR_REFDIV, w0);
            apb(1'b1, ADDR_TRIM, w0);
            rchk(ADDR_PRESET0, w0 & PRESET_MASK);
            rchk(ADDR_PRESET1, ~w0 & PRESET_MASK);
            rchk(ADDR_REFDIV, {24'h0, w0[7:0]});
            check(xtal_trim, w0[2:0]);
        end
        $display("register test done");
        preset_sel <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, ADDR_PRESET0, pw(5'h00, 9'h01F, 2'h0, 1'b0, 1'b0, 2'(c)));
            cyc(3);
            check(cp_current, (c == 3) ? CP_1000UA : 2'(c));
        end
        $display("pump current test done");
        for (int m = 0; m < 8; m++) begin
            w0 = pw(5'h00, 9'h01F, 2'($random(seed)), 1'b0, 1'b0, 2'h0);
            w1 = pw(5'h00, 9'h01F, 2'($random(seed)), 1'b1, m[0], 2'h0);
            apb(1'b1, ADDR_PRESET0, w0);
            apb(1'b1, ADDR_PRESET1, w1);
            preset_sel <= m[1];
            tx_bit <= m[1] & m[2];
            cyc(4);
            check(amp_att, m[1] ? w1[7:6] : w0[7:6]);
            check(amp_on, m[1] & (m[0] | m[2]));
            check(fsk_load, m[1] & m[0] & m[2]);
            check(vco_run, 1'b1);
            apb(1'b0, ADDR_STATUS, 32'h0);
            check(rd[1], m[1]);
            if (!m[1] || m[0]) begin
                check(rd[6:5], m[1] ? (w1[7:6] == 2'h3 ? 2'h2 : w1[7:6]) : 2'h3);
            end
        end
        $display("amplifier and keying test done");
        apb(1'b1, ADDR_SLICE, 32'h0);
        cyc(3);
        check(slicer_hold, 1'b0);
        apb(1'b1, ADDR_SLICE, 32'h1);
        cyc(3);
        check(slicer_hold, 1'b1);
        $display("slicer test done");
        preset_sel <= 1'b0;
        tx_bit <= 1'b0;
        div_round(5'h00, 9'h01F, 8'hFF);
        div_round(5'($random(seed)), 9'h01F + 9'($unsigned($random(seed)) % 4),
                  8'($random(seed)));
        $display("divider test done");
        tally_and_finish();
    end
endmodule : tb_top
